// ### hdl/msd_map.svh
`ifndef MSD_MAP_SVH
`define MSD_MAP_SVH

`define MSD_FC_READ          8'h03
`define MSD_FC_WRITE         8'h10
`define MSD_CRC_INIT         16'hffff
`define MSD_CRC_POLY         16'ha001
`define MSD_STREAM_ADDRS     8'd12
`define MSD_PHYS_STREAMS     4'd8
`define MSD_TOT_FIRST        16'd5001
`define MSD_TOT_LAST         16'd5148
`define MSD_FLT_FIRST        16'd7001
`define MSD_FLT_LAST         16'd7099
`define MSD_VTOT_FIRST       16'd9001
`define MSD_VFLT_FIRST       16'd8001
`define MSD_TOT_STRIDE       16'd200
`define MSD_FLT_STRIDE       16'd100
`define MSD_STD_BYTES        9'd2
`define MSD_WIDE_BYTES       9'd4
`define MSD_MAX_DATA_BYTES   18'd250
`define MSD_READ_BODY        9'd6
`define MSD_WRITE_HDR        9'd7
`define MSD_READ_RESP_HDR    9'd3
`define MSD_WRITE_RESP_LEN   9'd6
`define MSD_CRC_BYTES        9'd2
`define MSD_ETH_PORT         4'd8
`define MSD_CLK_MHZ          250
`define MSD_RESP_DELAY_US    1000

`endif

// ### hdl/msd_pkg.sv
package msd_pkg;

    typedef enum logic [1:0] {
        MSD_MAP_STANDARD,
        MSD_MAP_WIDE,
        MSD_MAP_USER
    } msd_mode_type;

    typedef enum logic [1:0] {
        MSD_LINE_SINGLE_ENDED,
        MSD_LINE_TWO_WIRE_MULTIDROP,
        MSD_LINE_FOUR_WIRE_MULTIDROP,
        MSD_LINE_FOUR_WIRE_POINT_TO_POINT
    } msd_line_type;

    typedef enum logic [2:0] {
        MSD_ST_IDLE,
        MSD_ST_PARSE,
        MSD_ST_CHECK,
        MSD_ST_EXEC,
        MSD_ST_DELAY,
        MSD_ST_SEND
    } msd_state_type;

endpackage

// ### hdl/msd_crc_byte.sv
`timescale 1ns/1ps
`include "msd_map.svh"

// one whole byte folded per call: eight right shifts unrolled by the loop
module msd_crc_byte (
    input  wire logic [15:0] crcIn,
    input  wire logic [7:0]  dataIn,
    output logic      [15:0] crcOut
);
    always_comb begin
        crcOut = crcIn ^ {8'h00, dataIn};
        for (int i = 0; i < 8; i++) begin
            crcOut = crcOut[0] ? ((crcOut >> 1) ^ `MSD_CRC_POLY) : (crcOut >> 1);
        end
    end
endmodule

// ### hdl/msd_dispatch.sv
// What this block does
// [R1] slave only; reply only if all registers defined
// [R2] function 3 reads contiguous register range
// [R3] function 16 writes contiguous register range
// [R4] standard map: two bytes per register
// [R5] wide map: four bytes per register
// [R6] wide map serves twelve streams, eight plus four
// [R7] base address exposes every stream's windows
// [R8] base plus k-1 exposes stream k only
// [R9] others avoid the twelve consecutive addresses
// [R10] multidrop lines wait response delay, default 1ms
// [R11] single-ended and point-to-point lines: no delay
// [R12] ethernet uses tcp framing, serial uses line framing
// [R13] each port selects standard, wide or user map
// [R14] serial ports configured incl. address matched here
// [R15] eight serial ports, extras only when fitted
// [R16] ethernet has its own map mode
// [R17] crc16 poly a001, all-ones start, eight shifts
// [R18] read reply byte count precedes register data
// [R19] foreign device addresses silently ignored
// [R20] other function codes change nothing
// [R21] bad checksum frames dropped silently
`timescale 1ns/1ps
`include "msd_map.svh"

module msd_dispatch
    import msd_pkg::*;
#(
    parameter int unsigned RESP_DELAY_DEFAULT_CYCLES = `MSD_RESP_DELAY_US * `MSD_CLK_MHZ
) (
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    input  wire logic         rxValid,
    input  wire logic [7:0]   rxByte,
    input  wire logic         rxEnd,
    input  wire logic [3:0]   rxPort,
    input  wire logic [17:0]  portMode,
    input  wire logic [15:0]  portLine,
    input  wire logic [7:0]   portText,
    input  wire logic [71:0]  portDevAddr,
    input  wire logic [127:0] respDelayUs,
    input  wire logic [7:0]   respDelayCustom,
    input  wire logic         extSerialA,
    input  wire logic         extSerialB,
    input  wire logic         regDefined,
    input  wire logic [31:0]  regRdata,
    input  wire logic         txReady,
    output logic              busy,
    output logic              txValid,
    output logic [7:0]        txByte,
    output logic              txLast,
    output logic [3:0]        txPort,
    output logic [15:0]       regAddr,
    output logic [1:0]        regMode,
    output logic              regRead,
    output logic              regWrite,
    output logic [31:0]       regWdata
);
    msd_state_type stateQ;
    logic [7:0]  rxBuf [0:255];
    logic [7:0]  txBuf [0:255];
    logic [8:0]  rxCntQ;
    logic [3:0]  portQ;
    logic        dropQ;
    logic [15:0] crcQ;
    logic [15:0] crcM1Q;
    logic [15:0] crcM2Q;
    logic [15:0] startQ;
    logic [7:0]  cntQ;
    logic [7:0]  bnQ;
    logic [3:0]  devOffQ;
    logic        readQ;
    logic        wideQ;
    logic        needCrcQ;
    logic [7:0]  idxQ;
    logic        phaseQ;
    logic        mapOkQ;
    logic [23:0] delayQ;
    logic [8:0]  txIdxQ;

    // frame fields straight out of the receive buffer
    wire [7:0]  frmAddr  = rxBuf[0];
    wire [7:0]  frmFunc  = rxBuf[1];
    wire [15:0] frmStart = {rxBuf[2], rxBuf[3]};
    wire [15:0] frmCnt   = {rxBuf[4], rxBuf[5]};
    wire [7:0]  frmBn    = rxBuf[6];

    wire        isTcp    = (portQ == `MSD_ETH_PORT); // [R12]
    wire [1:0]  selMode  = portMode[2*portQ +: 2]; // [R13] [R16]
    wire [7:0]  selAddr  = portDevAddr[8*portQ +: 8]; // [R14]
    wire [1:0]  selLine  = isTcp ? 2'(MSD_LINE_SINGLE_ENDED) : portLine[2*portQ[2:0] +: 2];
    wire        selText  = !isTcp && portText[portQ[2:0]];
    wire        needCrc  = !isTcp && !selText; // [R17]
    wire        selWide  = (selMode == 2'(MSD_MAP_WIDE));
    wire [17:0] dataLen  = selWide ? {frmCnt, 2'b00} : {1'b0, frmCnt, 1'b0};
    wire [8:0]  bodyLen  = rxCntQ - (needCrc ? `MSD_CRC_BYTES : 9'd0);

    // port 0 and ethernet always exist; 1-2 and 3-7 need their extension hardware
    wire        rxFitted = (rxPort == 4'd0) || (rxPort == `MSD_ETH_PORT) ||
                           ((rxPort == 4'd1 || rxPort == 4'd2) && extSerialA) ||
                           (rxPort >= 4'd3 && rxPort <= 4'd7 && extSerialB); // [R15]

    wire [7:0]  addrDiff = frmAddr - selAddr;
    wire        addrOk   = (addrDiff == 8'h00) || (selWide && addrDiff < `MSD_STREAM_ADDRS); // [R8] [R19]
    wire        sizeOk   = (frmCnt != 16'h0000) && (dataLen <= `MSD_MAX_DATA_BYTES);
    wire        readOk   = (frmFunc == `MSD_FC_READ) && (bodyLen == `MSD_READ_BODY); // [R2]
    wire        writeOk  = (frmFunc == `MSD_FC_WRITE) && (dataLen == {10'h000, frmBn}) &&
                           (bodyLen == `MSD_WRITE_HDR + {1'b0, frmBn}); // [R3]
    wire        crcOk    = !needCrc ||
                           (crcM2Q == {rxBuf[8'(rxCntQ - 9'd2)], rxBuf[8'(rxCntQ - 9'd1)]}); // [R21]
    // unknown function codes fall out here and touch nothing
    wire        accept   = !dropQ && !rxCntQ[8] && addrOk && sizeOk && crcOk && (readOk || writeOk); // [R20]

    // stream address k-1 folds its own windows onto the full-map ranges
    wire [15:0] curReg   = startQ + {8'h00, idxQ};
    wire        isTot    = (curReg >= `MSD_TOT_FIRST) && (curReg <= `MSD_TOT_LAST);
    wire        isFlt    = (curReg >= `MSD_FLT_FIRST) && (curReg <= `MSD_FLT_LAST);
    wire        isVirt   = (devOffQ >= `MSD_PHYS_STREAMS); // [R6]
    wire [15:0] kSel     = {12'h000, isVirt ? devOffQ - `MSD_PHYS_STREAMS : devOffQ};
    wire [15:0] totOff   = 16'(`MSD_TOT_STRIDE * kSel) + (isVirt ? `MSD_VTOT_FIRST - `MSD_TOT_FIRST : 16'h0000);
    wire [15:0] fltOff   = 16'(`MSD_FLT_STRIDE * kSel) + (isVirt ? `MSD_VFLT_FIRST - `MSD_FLT_FIRST : 16'h0000);
    wire [15:0] mapReg   = (devOffQ == 4'h0) ? curReg : (isTot ? curReg + totOff : curReg + fltOff); // [R7] [R8]
    wire        mapOk    = (devOffQ == 4'h0) || isTot || isFlt;

    wire        lastIdx  = (idxQ == cntQ - 8'h01);
    wire [7:0]  dataOff  = wideQ ? {idxQ[5:0], 2'b00} : {idxQ[6:0], 1'b0};
    wire [7:0]  wrBase   = dataOff + 8'h07;

    // response delay only on multidrop lines; custom value in microseconds
    wire        dropLine = (selLine == 2'(MSD_LINE_TWO_WIRE_MULTIDROP)) ||
                           (selLine == 2'(MSD_LINE_FOUR_WIRE_MULTIDROP));
    wire [23:0] custDly  = 24'(respDelayUs[16*portQ[2:0] +: 16] * 24'(`MSD_CLK_MHZ));
    wire [23:0] dlyLoad  = !dropLine ? 24'h000000 :
                           (respDelayCustom[portQ[2:0]] ? custDly : 24'(RESP_DELAY_DEFAULT_CYCLES)); // [R10] [R11]

    // transmit byte selection: header reuses the request bytes
    wire [8:0]  txLen    = readQ ? `MSD_READ_RESP_HDR + {1'b0, bnQ} : `MSD_WRITE_RESP_LEN;
    wire [8:0]  txTotal  = txLen + (needCrcQ ? `MSD_CRC_BYTES : 9'd0);
    wire        txIsCrc  = (txIdxQ >= txLen);
    wire [7:0]  txSel    = (txIdxQ == txLen) ? crcQ[15:8] :
                           txIsCrc ? crcQ[7:0] :
                           (readQ && txIdxQ == 9'd2) ? bnQ : // [R18]
                           (readQ && txIdxQ > 9'd2) ? txBuf[8'(txIdxQ - `MSD_READ_RESP_HDR)] :
                           rxBuf[txIdxQ[7:0]];
    wire        txMove   = (stateQ == MSD_ST_SEND) && (!txValid || txReady);
    wire        txNew    = txMove && (txIdxQ < txTotal);

    wire        rxTake   = (stateQ == MSD_ST_IDLE) && rxValid;
    wire [15:0] crcIn    = (rxTake && rxCntQ == 9'd0) ? `MSD_CRC_INIT : crcQ;
    wire [7:0]  crcData  = (stateQ == MSD_ST_SEND) ? txSel : rxByte;
    wire [15:0] crcNext;

    msd_crc_byte uCrc (
        .crcIn  (crcIn),
        .dataIn (crcData),
        .crcOut (crcNext)
    );

    // receive side; bytes offered outside the idle state are not taken
    always_ff @(posedge clk_sys) begin
        if (rxTake && !rxCntQ[8]) begin
            rxBuf[rxCntQ[7:0]] <= rxByte;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rxCntQ <= 9'd0;
            portQ  <= 4'd0;
            dropQ  <= 1'b0;
        end else if (stateQ == MSD_ST_PARSE) begin
            rxCntQ <= 9'd0;
        end else if (rxTake) begin
            if (rxCntQ == 9'd0) begin
                portQ <= rxPort;
                dropQ <= !rxFitted; // [R15]
            end
            if (!rxCntQ[8]) begin
                rxCntQ <= rxCntQ + 9'd1;
            end
        end
    end

    // running crc; two back copies give the value before the trailing checksum
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            crcQ   <= `MSD_CRC_INIT;
            crcM1Q <= `MSD_CRC_INIT;
            crcM2Q <= `MSD_CRC_INIT;
        end else if (rxTake && !rxCntQ[8]) begin
            crcM2Q <= crcM1Q;
            crcM1Q <= crcIn;
            crcQ   <= crcNext; // [R17]
        end else if (stateQ == MSD_ST_DELAY) begin
            crcQ <= `MSD_CRC_INIT;
        end else if (txNew && !txIsCrc) begin
            crcQ <= crcNext; // [R17]
        end
    end

    // read data lands in the reply buffer, high-order byte first
    always_ff @(posedge clk_sys) begin
        if (stateQ == MSD_ST_EXEC && readQ && phaseQ) begin
            if (wideQ) begin
                txBuf[dataOff]        <= regRdata[31:24]; // [R5]
                txBuf[dataOff + 8'd1] <= regRdata[23:16];
                txBuf[dataOff + 8'd2] <= regRdata[15:8];
                txBuf[dataOff + 8'd3] <= regRdata[7:0];
            end else begin
                txBuf[dataOff]        <= regRdata[15:8]; // [R4]
                txBuf[dataOff + 8'd1] <= regRdata[7:0];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            stateQ <= MSD_ST_IDLE;
            idxQ   <= 8'h00;
            phaseQ <= 1'b0;
            delayQ <= 24'h000000;
            txIdxQ <= 9'd0;
        end else begin
            case (stateQ)
                MSD_ST_IDLE: begin
                    if (rxEnd) begin
                        stateQ <= MSD_ST_PARSE;
                    end
                end
                MSD_ST_PARSE: begin
                    idxQ   <= 8'h00;
                    phaseQ <= 1'b0;
                    stateQ <= accept ? MSD_ST_CHECK : MSD_ST_IDLE; // [R19] [R20] [R21]
                end
                MSD_ST_CHECK: begin
                    phaseQ <= !phaseQ;
                    if (phaseQ) begin
                        // one undefined register kills the whole reply
                        if (!(regDefined && mapOkQ)) begin
                            stateQ <= MSD_ST_IDLE; // [R1]
                        end else if (lastIdx) begin
                            idxQ   <= 8'h00;
                            stateQ <= MSD_ST_EXEC;
                        end else begin
                            idxQ <= idxQ + 8'h01;
                        end
                    end
                end
                MSD_ST_EXEC: begin
                    phaseQ <= !phaseQ;
                    if (phaseQ) begin
                        idxQ <= idxQ + 8'h01;
                        if (lastIdx) begin
                            delayQ <= dlyLoad;
                            stateQ <= MSD_ST_DELAY;
                        end
                    end
                end
                MSD_ST_DELAY: begin
                    txIdxQ <= 9'd0;
                    if (delayQ == 24'h000000) begin
                        stateQ <= MSD_ST_SEND;
                    end else begin
                        delayQ <= delayQ - 24'h000001; // [R10]
                    end
                end
                MSD_ST_SEND: begin
                    if (txNew) begin
                        txIdxQ <= txIdxQ + 9'd1;
                    end else if (txMove) begin
                        stateQ <= MSD_ST_IDLE;
                    end
                end
                default: begin
                    stateQ <= MSD_ST_IDLE;
                end
            endcase
        end
    end

    // request fields latched once the frame is accepted
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            startQ   <= 16'h0000;
            cntQ     <= 8'h00;
            bnQ      <= 8'h00;
            devOffQ  <= 4'h0;
            readQ    <= 1'b0;
            wideQ    <= 1'b0;
            needCrcQ <= 1'b0;
            regMode  <= 2'b00;
            txPort   <= 4'h0;
        end else if (stateQ == MSD_ST_PARSE && accept) begin
            startQ   <= frmStart;
            cntQ     <= frmCnt[7:0];
            bnQ      <= dataLen[7:0]; // [R18]
            devOffQ  <= addrDiff[3:0];
            readQ    <= (frmFunc == `MSD_FC_READ);
            wideQ    <= selWide;
            needCrcQ <= needCrc;
            regMode  <= selMode; // [R13]
            txPort   <= portQ;
        end
    end

    // register store requests: query, read and write share one address
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            regAddr  <= 16'h0000;
            regRead  <= 1'b0;
            regWrite <= 1'b0;
            regWdata <= 32'h00000000;
            mapOkQ   <= 1'b0;
        end else begin
            regRead  <= (stateQ == MSD_ST_EXEC) && !phaseQ && readQ; // [R2]
            regWrite <= (stateQ == MSD_ST_EXEC) && !phaseQ && !readQ; // [R3]
            if ((stateQ == MSD_ST_CHECK || stateQ == MSD_ST_EXEC) && !phaseQ) begin
                regAddr <= mapReg;
                mapOkQ  <= mapOk;
                regWdata <= wideQ ? {rxBuf[wrBase], rxBuf[wrBase + 8'd1], rxBuf[wrBase + 8'd2],
                                     rxBuf[wrBase + 8'd3]} :
                                    {16'h0000, rxBuf[wrBase], rxBuf[wrBase + 8'd1]};
            end
        end
    end

    // transmit stream with back-pressure
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            busy    <= 1'b0;
            txValid <= 1'b0;
            txByte  <= 8'h00;
            txLast  <= 1'b0;
        end else begin
            busy <= (stateQ != MSD_ST_IDLE) || rxEnd;
            if (txNew) begin
                txValid <= 1'b1;
                txByte  <= txSel;
                txLast  <= (txIdxQ == txTotal - 9'd1);
            end else if (txMove) begin
                txValid <= 1'b0;
                txLast  <= 1'b0;
            end
        end
    end
endmodule

// ### verif/msd_dispatch_properties.sv
`timescale 1ns/1ps
module msd_dispatch_properties
    import msd_pkg::*;
#(
    parameter int unsigned RESP_DELAY_DEFAULT_CYCLES = 250000
) (
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic        rxEnd,
    input wire logic        busy,
    input wire logic        txValid,
    input wire logic        txReady,
    input wire logic [7:0]  txByte,
    input wire logic        txLast,
    input wire logic        regRead,
    input wire logic        regWrite,
    input wire logic [1:0]  regMode,
    input wire logic [31:0] regWdata
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    property p_start;  rxEnd && !busy |=> busy; endproperty
    property p_slave;  $rose(busy) |-> $past(rxEnd); endproperty
    property p_quiet;  !busy |-> !txValid && !regRead && !regWrite; endproperty
    property p_hold;   txValid && !txReady |=> txValid && $stable(txByte) && $stable(txLast); endproperty
    property p_rdPulse; regRead |=> !regRead; endproperty
    property p_wrPulse; regWrite |=> !regWrite; endproperty
    property p_stdWord; regWrite && regMode == MSD_MAP_STANDARD |-> regWdata[31:16] == 16'h0000; endproperty
    property p_noRegInTx; txValid |-> !regWrite && !regRead; endproperty
    property p_lastEnds; txValid && txReady && txLast |=> !txValid; endproperty
    a_start: assert property (p_start) else $error("frame end did not start work");
    a_slave: assert property (p_slave) else $error("work started without a frame");
    a_quiet: assert property (p_quiet) else $error("activity while idle");
    a_hold: assert property (p_hold) else $error("reply byte moved while stalled");
    a_rdPulse: assert property (p_rdPulse) else $error("read strobe too long");
    a_wrPulse: assert property (p_wrPulse) else $error("write strobe too long");
    a_stdWord: assert property (p_stdWord) else $error("standard write wider than two bytes");
    a_noRegInTx: assert property (p_noRegInTx) else $error("register access during reply");
    a_lastEnds: assert property (p_lastEnds) else $error("reply continued after last byte");
    c_write: cover property (regWrite);
    c_stall: cover property (txValid && !txReady);
    c_wide: cover property (txValid && txLast && regMode == MSD_MAP_WIDE);
endmodule

bind msd_dispatch msd_dispatch_properties #(
    .RESP_DELAY_DEFAULT_CYCLES(RESP_DELAY_DEFAULT_CYCLES)
) u_props (.clk_sys, .rst_n, .rxEnd, .busy, .txValid, .txReady, .txByte, .txLast,
    .regRead, .regWrite, .regMode, .regWdata);

// ### verif/msd_master_model.sv
`timescale 1ns/1ps
module msd_master_model (
    input  wire logic       clk_sys,
    input  wire logic       stall,
    input  wire logic       txValid,
    input  wire logic [7:0] txByte,
    input  wire logic       txLast,
    output logic            rxValid,
    output logic [7:0]      rxByte,
    output logic            rxEnd,
    output logic [3:0]      rxPort,
    output logic            txReady
);
    logic [7:0] got[$];
    int         lat;
    time        tEnd;
    logic       first = 1'b0;
    initial begin
        rxValid = 1'b0;
        rxByte = 8'h00;
        rxEnd = 1'b0;
        rxPort = 4'h0;
        txReady = 1'b1;
    end
    function automatic logic [15:0] crc16(input logic [7:0] b[$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (b[i]) begin
            c = c ^ {8'h00, b[i]};
            for (int k = 0; k < 8; k++)
                c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
        end
        return c;
    endfunction
    // crc: 0 none (text or tcp framing), 1 good, 2 corrupted
    task automatic send(input logic [3:0] port, input logic [7:0] b[$], input int crc);
        logic [15:0] c;
        c = crc16(b);
        if (crc != 0) begin
            b.push_back(c[15:8] ^ {7'h00, crc == 2});
            b.push_back(c[7:0]);
        end
        got.delete();
        first = 1'b1;
        rxPort = port;
        foreach (b[i]) begin
            @(negedge clk_sys);
            rxValid = 1'b1;
            rxByte = b[i];
        end
        @(negedge clk_sys);
        rxValid = 1'b0;
        // released line shows the inverse so a stale byte is never mistaken for data
        rxByte = ~rxByte;
        rxEnd = 1'b1;
        @(negedge clk_sys);
        rxEnd = 1'b0;
    endtask
    always @(posedge clk_sys) begin
        if (rxEnd)
            tEnd = $time;
        if (txValid && first) begin
            lat = int'(($time - tEnd) / 4);
            first = 1'b0;
        end
        if (txValid && txReady)
            got.push_back(txByte);
    end
    // slow sink takes every other cycle
    always @(negedge clk_sys)
        txReady <= stall ? ~txReady : 1'b1;
endmodule

// ### verif/modbus_slave_stream_dispatch_tb.sv
`timescale 1ns/1ps
module modbus_slave_stream_dispatch_tb;
    import msd_pkg::*;
    localparam int DLY = 20;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic        stall = 1'b0;
    logic        rxValid, rxEnd, extSerialA, extSerialB, regDefined, txReady;
    logic        busy, txValid, txLast, regRead, regWrite;
    logic [7:0]  rxByte, txByte, portText;
    logic [3:0]  rxPort, txPort;
    logic [17:0] portMode;
    logic [15:0] portLine, regAddr;
    logic [71:0] portDevAddr;
    logic [1:0]  regMode;
    logic [31:0] regRdata, regWdata;
    logic [127:0] respDelayUs;
    logic [7:0]  respDelayCustom;
    logic [15:0] ra[$], wa[$];
    logic [31:0] wd[$];
    int          bad_count = 0;
    int          n_checks = 0;
    msd_dispatch #(.RESP_DELAY_DEFAULT_CYCLES(DLY)) uut (.clk_sys, .rst_n, .rxValid, .rxByte, .rxEnd, .rxPort,
        .portMode, .portLine, .portText, .portDevAddr, .respDelayUs, .respDelayCustom,
        .extSerialA, .extSerialB, .regDefined, .regRdata, .txReady, .busy, .txValid, .txByte, .txLast,
        .txPort, .regAddr, .regMode, .regRead, .regWrite, .regWdata);
    msd_master_model m (.clk_sys, .stall, .txValid, .txByte, .txLast, .rxValid, .rxByte, .rxEnd, .rxPort, .txReady);
    always #2 clk_sys = ~clk_sys;
    // store: all below 10000 exist except one hole
    assign regDefined = (regAddr < 16'd10000) && (regAddr != 16'd999);
    always @(negedge clk_sys)
        if (regRead)
            regRdata <= {~regAddr, regAddr};
    always @(posedge clk_sys) begin
        if (regRead)
            ra.push_back(regAddr);
        if (regWrite) begin
            wa.push_back(regAddr);
            wd.push_back(regWdata);
        end
    end
    task automatic close_out();
        if (bad_count == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input bit ok, input string msg);
        n_checks++;
        if (!ok) begin
            bad_count++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask
    task automatic run(input logic [3:0] p, input logic [7:0] b[$], input int crc);
        ra.delete();
        wa.delete();
        wd.delete();
        m.send(p, b, crc);
        for (int i = 0; i < 3000 && busy !== 1'b0; i++)
            @(negedge clk_sys);
        repeat (4) @(negedge clk_sys);
    endtask
    task automatic expect_reply(input logic [7:0] e[$], input bit crc);
        logic [15:0] c;
        c = m.crc16(e);
        if (crc) begin
            e.push_back(c[15:8]);
            e.push_back(c[7:0]);
        end
        chk(m.got.size() == e.size(), "reply length");
        foreach (e[i])
            if (i < m.got.size())
                chk(m.got[i] === e[i], "reply byte");
    endtask
    task automatic t_read_std();
        run(4'h0, '{8'h11, 8'h03, 8'h01, 8'h2c, 8'h00, 8'h02}, 1);
        expect_reply('{8'h11, 8'h03, 8'h04, 8'h01, 8'h2c, 8'h01, 8'h2d}, 1);
        chk(ra.size() == 2 && ra[0] === 16'd300 && ra[1] === 16'd301, "read order");
    endtask
    task automatic t_delay();
        int l0;
        l0 = m.lat;
        for (int p = 0; p < 3; p++) begin
            portLine[2*p +: 2] = (p == 0) ? 2'd3 : 2'(p);
            run(4'(p), '{8'h11, 8'h03, 8'h01, 8'h2c, 8'h00, 8'h02}, 1);
            chk(m.lat == l0 + ((p == 0) ? 0 : DLY), "response delay");
        end
        // one microsecond of custom delay is 250 cycles
        respDelayCustom[1] = 1'b1;
        respDelayUs[31:16] = 16'd1;
        run(4'h1, '{8'h11, 8'h03, 8'h01, 8'h2c, 8'h00, 8'h02}, 1);
        chk(m.lat == l0 + 250, "custom response delay");
        respDelayCustom[1] = 1'b0;
    endtask
    task automatic t_write_std();
        stall = 1'b1;
        run(4'h0, '{8'h11, 8'h10, 8'h00, 8'h64, 8'h00, 8'h02, 8'h04, 8'h12, 8'h34, 8'hab, 8'hcd}, 1);
        stall = 1'b0;
        expect_reply('{8'h11, 8'h10, 8'h00, 8'h64, 8'h00, 8'h02}, 1);
        chk(wa.size() == 2 && wa[0] === 16'd100 && wa[1] === 16'd101, "write address");
        chk(wd.size() == 2 && wd[0] === 32'h00001234 && wd[1] === 32'h0000abcd, "write data");
    endtask
    task automatic t_refuse();
        logic [7:0] w[$];
        w = '{8'h11, 8'h10, 8'h00, 8'h64, 8'h00, 8'h01, 8'h02, 8'h12, 8'h34};
        w[0] = 8'h12;
        run(4'h0, w, 1);
        chk(m.got.size() == 0 && wa.size() == 0, "foreign address answered");
        w[0] = 8'h11;
        w[1] = 8'h04;
        run(4'h0, w, 1);
        chk(m.got.size() == 0 && wa.size() == 0, "unknown code acted on");
        w[1] = 8'h10;
        run(4'h0, w, 2);
        chk(m.got.size() == 0 && wa.size() == 0, "bad checksum acted on");
        run(4'h3, w, 1);
        chk(m.got.size() == 0 && wa.size() == 0, "unfitted port answered");
        extSerialB = 1'b1;
        run(4'h3, w, 1);
        chk(wa.size() == 1 && m.got.size() == 8, "fitted port silent");
        chk(txPort === 4'h3, "reply port");
        w[2] = 8'h03;
        w[3] = 8'he7;
        run(4'h0, w, 1);
        chk(m.got.size() == 0 && wa.size() == 0, "undefined register written");
    endtask
    task automatic t_wide_eth();
        portMode[17:16] = 2'd1;
        // no other station sits in 0x20..0x2b
        portDevAddr[71:64] = 8'h20;
        run(4'h8, '{8'h22, 8'h03, 8'h13, 8'h89, 8'h00, 8'h01}, 0);
        expect_reply('{8'h22, 8'h03, 8'h04, 8'hea, 8'he6, 8'h15, 8'h19}, 0);
        run(4'h8, '{8'h20, 8'h03, 8'h1b, 8'hbd, 8'h00, 8'h01}, 0);
        chk(ra.size() == 1 && ra[0] === 16'd7101, "base window");
        run(4'h8, '{8'h29, 8'h03, 8'h1b, 8'h59, 8'h00, 8'h01}, 0);
        chk(ra.size() == 1 && ra[0] === 16'd8101, "virtual stream window");
    endtask
    initial begin
        portMode = 18'h0;
        portLine = 16'h0;
        portText = 8'h00;
        portDevAddr = {9{8'h11}};
        extSerialA = 1'b1;
        extSerialB = 1'b0;
        regRdata = 32'h0;
        respDelayUs = 128'h0;
        respDelayCustom = 8'h00;
        repeat (4) @(negedge clk_sys);
        chk(busy === 1'b0 && txValid === 1'b0 && regWrite === 1'b0, "reset state");
        rst_n = 1'b1;
        t_read_std();
        t_delay();
        t_write_std();
        t_refuse();
        t_wide_eth();
        close_out();
    end
    // whole sequence needs well under a tenth of this
    initial begin
        #200000;
        bad_count++;
        close_out();
    end
endmodule
